// >>> rtl/sdb_channel.sv
/*
  Sound DMA channel with double-buffered pointer pairs, an AHB-Lite
  register slave and a request/grant port toward the bus controller.
  Assumes one clock, AHB-Lite single word transfers, and a memory side
  that returns the four words of a unit on mem_ack after mem_req.
*/
// Design decisions made here: register access over AHB-Lite and the register addresses.
module sdb_channel
  import sdb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic snd_req,
  input wire logic vid_req,
  input wire logic cur_req,
  input wire logic bus_cycle_done,
  output logic snd_grant,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  output logic snd_irq
);

  sdb_ptr_if pa ();
  sdb_ptr_if pb ();

  sdb_ptr_pair u_pair_a (.hclk(hclk), .hresetn(hresetn), .p(pa));
  sdb_ptr_pair u_pair_b (.hclk(hclk), .hresetn(hresetn), .p(pb));

  // AHB-Lite address phase capture
  logic wr_pend_ff, nxt_wr_pend;
  logic rd_pend_ff, nxt_rd_pend;
  logic [11:0] addr_ff, nxt_addr;
  logic [31:0] rdata_ff, nxt_rdata;

  // Channel state
  logic ovr_ff, nxt_ovr;
  logic int_ff, nxt_int;
  logic ab_ff, nxt_ab;
  logic prog_a_ff, nxt_prog_a;
  logic prog_b_ff, nxt_prog_b;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic mask_ff, nxt_mask;
  logic grant_ff, nxt_grant;
  logic [31:0] maddr_ff, nxt_maddr;

  logic ahb_take, wr_ev, wr_cura, wr_enda, wr_curb, wr_endb;
  logic fetch_busy, fetch_done, fetch_start, enabled;
  logic act_at_end, act_stop, act_last;
  logic [31:0] act_cur, act_end;
  logic buf_done;

  assign ahb_take = hsel && hready && htrans[1];
  assign wr_ev = wr_pend_ff;
  assign wr_cura = wr_ev && (addr_ff == SDB_CURA_OFS);
  assign wr_enda = wr_ev && (addr_ff == SDB_ENDA_OFS);
  assign wr_curb = wr_ev && (addr_ff == SDB_CURB_OFS);
  assign wr_endb = wr_ev && (addr_ff == SDB_ENDB_OFS);

  assign pa.wr_cur = wr_cura;
  assign pa.wr_end = wr_enda;
  assign pa.wdata = hwdata;
  assign pb.wr_cur = wr_curb;
  assign pb.wr_end = wr_endb;
  assign pb.wdata = hwdata;

  assign enabled = ctrl_ff[SDB_CTRL_EN_BIT];
  assign act_cur = ab_ff ? pb.cur : pa.cur;
  assign act_end = ab_ff ? pb.end_ptr : pa.end_ptr;
  assign act_at_end = ab_ff ? pb.at_end : pa.at_end;
  assign act_stop = act_end[SDB_END_STOP_BIT];
  // Last bit ends the buffer after the current unit even when the compare does not match
  assign act_last = act_end[SDB_END_LAST_BIT];

  // The unit just fetched was the buffer's last when the pointer sat on end
  assign buf_done = fetch_done && (act_at_end || act_last);
  assign pa.adv = fetch_done && !ab_ff && !buf_done;
  assign pb.adv = fetch_done && ab_ff && !buf_done;

  // Halted while overrun is set or the active pair is not programmed
  assign fetch_start = enabled && !ovr_ff && (ab_ff ? prog_b_ff : prog_a_ff) &&
                       snd_req && !vid_req && !cur_req && bus_cycle_done &&
                       !fetch_busy && !grant_ff;

  sdb_fetch_ctl u_fetch (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(fetch_start),
    .mem_ack(mem_ack),
    .busy(fetch_busy),
    .done(fetch_done)
  );

  always_comb begin
    nxt_wr_pend = ahb_take && hwrite;
    nxt_rd_pend = ahb_take && !hwrite;
    nxt_addr = ahb_take ? haddr[11:0] : addr_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_grant = fetch_start;
    nxt_maddr = fetch_start ? act_cur : maddr_ff;
    if (wr_ev && addr_ff == SDB_CTRL_OFS) begin
      nxt_ctrl = hwdata[7:0];
    end
    if (wr_ev && addr_ff == SDB_MASK_OFS) begin
      nxt_mask = hwdata[0];
    end
    if (ahb_take && !hwrite) begin
      if (haddr[11:0] == SDB_CURA_OFS) begin
        nxt_rdata = pa.cur;
      end else if (haddr[11:0] == SDB_ENDA_OFS) begin
        nxt_rdata = pa.end_ptr;
      end else if (haddr[11:0] == SDB_CURB_OFS) begin
        nxt_rdata = pb.cur;
      end else if (haddr[11:0] == SDB_ENDB_OFS) begin
        nxt_rdata = pb.end_ptr;
      end else if (haddr[11:0] == SDB_CTRL_OFS) begin
        nxt_rdata = {24'h0, ctrl_ff};
      end else if (haddr[11:0] == SDB_STAT_OFS) begin
        nxt_rdata = {29'h0, ovr_ff, int_ff, ab_ff};
      end else if (haddr[11:0] == SDB_MASK_OFS) begin
        nxt_rdata = {31'h0, mask_ff};
      end else begin
        nxt_rdata = 32'h0;
      end
    end
  end

  // State machine: moves only on buffer completion or end-pointer write
  always_comb begin
    nxt_ovr = ovr_ff;
    nxt_int = int_ff;
    nxt_ab = ab_ff;
    nxt_prog_a = prog_a_ff;
    nxt_prog_b = prog_b_ff;
    if (buf_done) begin
      nxt_int = 1'b1;
      if (ab_ff) begin
        nxt_prog_b = 1'b0;
      end else begin
        nxt_prog_a = 1'b0;
      end
      if (act_stop) begin
        // Back to idle: nothing left programmed to run
        nxt_prog_a = 1'b0;
        nxt_prog_b = 1'b0;
      end else if (ab_ff ? prog_a_ff : prog_b_ff) begin
        nxt_ab = !ab_ff;
      end else begin
        nxt_ab = !ab_ff;
        nxt_ovr = 1'b1;
      end
    end
    // Writes are applied after the completion: a same-cycle write wins for the programmed flags; ab_ff and the interrupt flag keep the completion's value
    if (wr_enda) begin
      nxt_prog_a = 1'b1;
      if (!ab_ff || ovr_ff) begin
        nxt_int = 1'b0;
        nxt_ovr = 1'b0;
        if (ovr_ff) begin
          nxt_ab = 1'b0;
        end
      end
    end
    if (wr_endb) begin
      nxt_prog_b = 1'b1;
      if (ab_ff || ovr_ff) begin
        nxt_int = 1'b0;
        nxt_ovr = 1'b0;
        if (ovr_ff) begin
          nxt_ab = 1'b1;
        end
      end
    end
    if (buf_done && (wr_enda || wr_endb)) begin
      // A completion in the same cycle still reports its event
      nxt_int = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 12'h000;
      rdata_ff <= 32'h0000_0000;
      ovr_ff <= SDB_STATE_RST[SDB_STAT_OVR_BIT];
      int_ff <= SDB_STATE_RST[SDB_STAT_INT_BIT];
      ab_ff <= SDB_STATE_RST[SDB_STAT_AB_BIT];
      prog_a_ff <= 1'b0;
      prog_b_ff <= 1'b0;
      ctrl_ff <= SDB_CTRL_RST;
      mask_ff <= 1'b0;
      grant_ff <= 1'b0;
      maddr_ff <= SDB_PTR_RST;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      rd_pend_ff <= nxt_rd_pend;
      addr_ff <= nxt_addr;
      rdata_ff <= nxt_rdata;
      ovr_ff <= nxt_ovr;
      int_ff <= nxt_int;
      ab_ff <= nxt_ab;
      prog_a_ff <= nxt_prog_a;
      prog_b_ff <= nxt_prog_b;
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      grant_ff <= nxt_grant;
      maddr_ff <= nxt_maddr;
    end
  end

  // Zero wait states: every access completes in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign snd_grant = grant_ff;
  assign mem_req = fetch_busy;
  assign mem_addr = maddr_ff;
  assign snd_irq = int_ff && mask_ff;

endmodule : sdb_channel

// >>> rtl/sdb_fetch_ctl.sv
/*
  Fetch sequencer: takes a grant and counts the four words of one unit.
  Assumes the memory side returns one word per mem_ack pulse.
*/
module sdb_fetch_ctl
  import sdb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic mem_ack,
  output logic busy,
  output logic done
);

  sdb_fetch_t st_ff, nxt_st;
  logic [2:0] cnt_ff, nxt_cnt;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    done = 1'b0;
    case (st_ff)
      SDB_FS_IDLE: begin
        if (start) begin
          nxt_st = SDB_FS_DATA;
          nxt_cnt = 3'h0;
        end
      end
      SDB_FS_DATA: begin
        if (mem_ack) begin
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == SDB_WORDS_PER_UNIT - 3'h1) begin
            nxt_st = SDB_FS_IDLE;
            done = 1'b1;
          end
        end
      end
      default: nxt_st = SDB_FS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= SDB_FS_IDLE;
      cnt_ff <= 3'h0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (st_ff != SDB_FS_IDLE);

endmodule : sdb_fetch_ctl

// >>> rtl/sdb_pkg.sv
/*
  Package for the sound DMA double-buffer channel: register offsets,
  field positions, reset values and the state encoding.
  Assumes a single 100 MHz clock domain and an AHB-Lite register port.
*/
package sdb_pkg;

  localparam logic [11:0] SDB_CURA_OFS = 12'h180;
  localparam logic [11:0] SDB_ENDA_OFS = 12'h184;
  localparam logic [11:0] SDB_CURB_OFS = 12'h188;
  localparam logic [11:0] SDB_ENDB_OFS = 12'h18c;
  localparam logic [11:0] SDB_CTRL_OFS = 12'h190;
  localparam logic [11:0] SDB_STAT_OFS = 12'h194;
  localparam logic [11:0] SDB_MASK_OFS = 12'h198;

  localparam int SDB_CTRL_EN_BIT = 0;
  localparam int SDB_END_LAST_BIT = 30;
  localparam int SDB_END_STOP_BIT = 31;
  localparam int SDB_PAGE_BITS = 12;
  localparam int SDB_ALIGN_BITS = 4;
  localparam int SDB_STAT_OVR_BIT = 2;
  localparam int SDB_STAT_INT_BIT = 1;
  localparam int SDB_STAT_AB_BIT = 0;

  localparam logic [7:0] SDB_UNIT_BYTES = 8'h10;
  localparam logic [2:0] SDB_WORDS_PER_UNIT = 3'h4;
  localparam logic [2:0] SDB_STATE_RST = 3'h6;
  localparam logic [31:0] SDB_PTR_RST = 32'h0000_0000;
  localparam logic [7:0] SDB_CTRL_RST = 8'h00;

  typedef enum logic [1:0] {
    SDB_FS_IDLE,
    SDB_FS_ADDR,
    SDB_FS_DATA
  } sdb_fetch_t;

endpackage : sdb_pkg

// >>> rtl/sdb_ptr_if.sv
/*
  Interface carrying one pointer pair between the channel core and its
  pointer stores. Assumes the core owns write strobes and reads data back.
*/
interface sdb_ptr_if;
  logic wr_cur;
  logic wr_end;
  logic adv;
  logic [31:0] wdata;
  logic [31:0] cur;
  logic [31:0] end_ptr;
  logic at_end;

  modport core (output wr_cur, output wr_end, output adv, output wdata,
                input cur, input end_ptr, input at_end);
  modport store (input wr_cur, input wr_end, input adv, input wdata,
                 output cur, output end_ptr, output at_end);
endinterface : sdb_ptr_if

// >>> rtl/sdb_ptr_pair.sv
/*
  One current/end pointer pair. Advances the current pointer by one
  four-word unit inside a 4 KB page. Assumes strobes are one-cycle pulses.
*/
module sdb_ptr_pair
  import sdb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  sdb_ptr_if.store p
);

  logic [31:0] cur_ff, nxt_cur;
  logic [31:0] end_ff, nxt_end;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_end = end_ff;
    if (p.wr_cur) begin
      nxt_cur = {p.wdata[31:SDB_ALIGN_BITS], 4'h0};
    end else if (p.adv) begin
      // Carry stops at the page boundary on purpose
      nxt_cur[SDB_PAGE_BITS-1:0] = cur_ff[SDB_PAGE_BITS-1:0] + {4'h0, SDB_UNIT_BYTES};
    end
    if (p.wr_end) begin
      nxt_end = {p.wdata[31:SDB_ALIGN_BITS], 4'h0};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff <= SDB_PTR_RST;
      end_ff <= SDB_PTR_RST;
    end else begin
      cur_ff <= nxt_cur;
      end_ff <= nxt_end;
    end
  end

  assign p.cur = cur_ff;
  assign p.end_ptr = end_ff;
  // Only the low page bits take part in the end test
  assign p.at_end = (cur_ff[SDB_PAGE_BITS-1:SDB_ALIGN_BITS] ==
                     end_ff[SDB_PAGE_BITS-1:SDB_ALIGN_BITS]);

endmodule : sdb_ptr_pair

// >>> tb/sdb_monitor.sv
/*
  Checker on the channel fetch port.
  Assumes it sees only sdb_channel ports; attached by the bind below.
*/
module sdb_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic snd_req,
  input wire logic vid_req,
  input wire logic cur_req,
  input wire logic bus_cycle_done,
  input wire logic snd_grant,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] acks_ff;
  logic [2:0] nxt_acks;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Words taken so far, so unit length is judged independently of the design
  always_comb begin
    nxt_acks = mem_req ? acks_ff + {2'h0, mem_ack} : 3'h0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) acks_ff <= 3'h0;
    else acks_ff <= nxt_acks;
  end
  sequence s_blocked;
    !snd_req || vid_req || cur_req || !bus_cycle_done;
  endsequence
  sequence s_last_word;
    mem_req && mem_ack && acks_ff == 3'h3;
  endsequence
  a_grant_cause: assert property (s_blocked |=> !snd_grant)
    else $error("grant after blocked cycle");
  a_grant_once: assert property (snd_grant |=> !snd_grant)
    else $error("grant too long");
  a_grant_fetch: assert property (snd_grant |-> mem_req)
    else $error("grant without fetch");
  a_fetch_start: assert property ($rose(mem_req) |-> snd_grant)
    else $error("fetch without grant");
  a_unit_align: assert property (mem_req |-> mem_addr[3:0] == 4'h0)
    else $error("unaligned unit");
  a_addr_hold: assert property (mem_req && !snd_grant |-> $stable(mem_addr))
    else $error("address moved in unit");
  a_fetch_hold: assert property (mem_req && !(mem_ack && acks_ff == 3'h3) |=> mem_req)
    else $error("unit cut short");
  a_unit_end: assert property (s_last_word |=> !mem_req && !snd_grant)
    else $error("unit too long");
endmodule : sdb_monitor

bind sdb_channel sdb_monitor u_mon (.hclk, .hresetn, .snd_req, .vid_req, .cur_req, .bus_cycle_done,
  .snd_grant, .mem_req, .mem_addr, .mem_ack);

// >>> tb/sdb_partner.sv
/*
  Sound requester, bus arbiter and memory beyond the channel.
  Assumes the channel clock and reset; slow spaces the words apart.
*/
module sdb_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_req,
  input wire logic slow,
  input wire logic block,
  output logic snd_req,
  output logic vid_req,
  output logic cur_req,
  output logic bus_cycle_done,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] words;
  logic [1:0] gap, ph;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {snd_req, vid_req, cur_req, bus_cycle_done, mem_ack} <= 5'h0;
      words <= 3'h0;
      gap <= 2'h0;
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      snd_req <= 1'b1;
      vid_req <= block & ph[0];
      cur_req <= block & ~ph[0];
      // Another master still owns the bus one cycle in four
      bus_cycle_done <= ph != 2'h3;
      mem_ack <= 1'b0;
      if (!mem_req) begin
        words <= 3'h0;
        gap <= 2'h0;
      end else if (gap != 2'h0) begin
        gap <= gap - 2'h1;
      end else if (words < 3'h4) begin
        mem_ack <= 1'b1;
        words <= words + 3'h1;
        gap <= slow ? 2'h2 : 2'h0;
      end
    end
  end
endmodule : sdb_partner

// >>> tb/tb.sv
/*
  Bench for sdb_channel: AHB-Lite master and fetch scenarios.
  Assumes sdb_partner and the checker bound from its own file.
*/
module tb
  import sdb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] a; logic [31:0] v;} sdb_row_t;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, slow = 1'b0, block = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_addr, rd;
  logic hreadyout, hresp, snd_req, vid_req, cur_req, bus_cycle_done, snd_grant, mem_req, mem_ack, snd_irq;
  logic [31:0] got_q[$];
  int err_total = 0;
  int check_count = 0;
  sdb_row_t rows[8] = '{'{32'h180, 32'h0}, '{32'h184, 32'h0}, '{32'h188, 32'h0}, '{32'h18c, 32'h0},
    '{32'h190, 32'h0}, '{32'h194, {29'h0, SDB_STATE_RST}}, '{32'h198, 32'h0}, '{32'h19c, 32'h0}};
  always #5 hclk = ~hclk;
  always @(posedge hclk) if (snd_grant === 1'b1) got_q.push_back(mem_addr);
  sdb_channel DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .snd_req, .vid_req, .cur_req, .bus_cycle_done, .snd_grant, .mem_req,
    .mem_addr, .mem_ack, .snd_irq);
  sdb_partner u_far (.hclk, .hresetn, .mem_req, .slow, .block, .snd_req, .vid_req, .cur_req,
    .bus_cycle_done, .mem_ack);
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] ev, input logic [31:0] got);
    check_count++;
    if (got !== ev) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, ev, got);
    end
  endtask : chk
  // Every wait is bounded so a hung handshake ends the run
  task automatic wait_ready;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      err_total++;
      final_report();
    end
  endtask : wait_ready
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb
  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] ev);
    ahb(1'b0, a, 32'h0);
    chk(what, ev, rd);
  endtask : rchk
  task automatic wait_units(input int n);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge hclk);
      if (got_q.size() >= n && mem_req === 1'b0) break;
    end
    if (i >= 3000) begin
      err_total++;
      final_report();
    end
  endtask : wait_units
  task automatic cmp_addr(input logic [31:0] e[$]);
    chk("unit count", 32'(e.size()), 32'(got_q.size()));
    foreach (e[k]) chk("unit address", e[k], got_q[k]);
    got_q.delete();
  endtask : cmp_addr
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[k]) rchk("reset register", rows[k].a, rows[k].v);
    $display("done reset");
    ahb(1'b1, 32'h180, 32'h2000_0ffb);
    rchk("pointer low bits", 32'h180, 32'h2000_0ff0);
    ahb(1'b1, 32'h184, 32'h2000_0010);
    rchk("status after end", 32'h194, 32'h0);
    ahb(1'b1, 32'h188, 32'h3000_0400);
    ahb(1'b1, 32'h18c, 32'h4000_0400);
    repeat (30) @(posedge hclk);
    chk("units while off", 32'h0, 32'(got_q.size()));
    block <= 1'b1;
    ahb(1'b1, 32'h198, 32'h1);
    ahb(1'b1, 32'h190, 32'h1);
    repeat (30) @(posedge hclk);
    chk("units while blocked", 32'h0, 32'(got_q.size()));
    block <= 1'b0;
    wait_units(4);
    cmp_addr('{32'h2000_0ff0, 32'h2000_0000, 32'h2000_0010, 32'h3000_0400});
    rchk("status overrun", 32'h194, 32'h6);
    chk("irq unmasked", 32'h1, {31'h0, snd_irq});
    $display("done stream");
    slow <= 1'b1;
    ahb(1'b1, 32'h180, 32'h5000_0100);
    ahb(1'b1, 32'h184, 32'h4000_0100);
    rchk("status resumed", 32'h194, 32'h0);
    wait_units(1);
    cmp_addr('{32'h5000_0100});
    rchk("status pair b", 32'h194, 32'h7);
    $display("done overrun");
    ahb(1'b1, 32'h188, 32'h6000_0200);
    ahb(1'b1, 32'h18c, 32'hc000_0200);
    wait_units(1);
    repeat (30) @(posedge hclk);
    cmp_addr('{32'h6000_0200});
    rchk("status stopped", 32'h194, 32'h3);
    ahb(1'b1, 32'h198, 32'h0);
    // Mask lands at the data-phase edge; look once it has settled
    @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, snd_irq});
    $display("done stop");
    final_report();
  end
endmodule : tb
